// ---- hw/exc_lp_map.svh ----
`ifndef EXC_LP_MAP_SVH
`define EXC_LP_MAP_SVH

// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define IDX_BREAK_STATUS 16'hfe00
`define IDX_RESET_SOURCE_STATUS 16'hfe01
`define IDX_BREAK_FLAG_CONTROL 16'hfe03
`define IDX_IRQ_FLAGS_LOW 16'hfe04
`define IDX_IRQ_FLAGS_MID 16'hfe05
`define IDX_IRQ_FLAGS_HIGH 16'hfe06
`define IDX_OPTION_WORD_ONE 16'hfe07

// ****************************************
// field positions
// ****************************************
`define BIT_BREAK_EXIT_WAIT 1
`define BIT_BREAK_CLEAR_ENABLE 7
`define BIT_SHORT_RECOVERY 0
`define RST_POR 7
`define RST_PIN 6
`define RST_WDOG 5
`define RST_ILL_OPCODE 4
`define RST_ILL_ADDR 3
`define RST_MON_ENTRY 2
`define RST_LOW_VOLT 1

// ****************************************
// reset values and timing counts
// ****************************************
`define RESET_SOURCE_INIT 8'h80
`define REG8_ZERO 8'h00
`define RECOVERY_LONG_CYCLES 13'd4096
`define RECOVERY_SHORT_CYCLES 13'd32

`endif

// ---- hw/exc_lp_pkg.sv ----
package exc_lp_pkg;

   // low-power sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_WAIT = 4'h2,
      ST_STOP = 4'h4,
      ST_RECOVER = 4'h8
   } lp_state_t;

   typedef logic [7:0] reg8_t;

endpackage

// ---- hw/exception_lowpower_control.sv ----
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "exc_lp_map.svh"

module exception_lowpower_control
   import exc_lp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] irq_req_i,
   input wire logic break_req_i,
   input wire logic break_exit_i,
   input wire logic wait_exec_i,
   input wire logic stop_exec_i,
   input wire logic por_evt_i,
   input wire logic pin_evt_i,
   input wire logic wdog_evt_i,
   input wire logic ill_opcode_evt_i,
   input wire logic ill_addr_evt_i,
   input wire logic mon_entry_evt_i,
   input wire logic low_volt_evt_i,
   output logic [4:0] irq_vector_o,
   output logic system_reset_o,
   output logic force_swi_vector_o,
   output logic break_state_o,
   output logic flag_clear_allow_o,
   output logic clear_i_mask_o,
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic stack_start_o,
   output logic [12:0] stab_count_o
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [4:0] rank_first(input logic [15:0] req);
      logic [4:0] num;
      num = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (req[i]) begin
            num = 5'(i + 1);
         end
      end
      return num;
   endfunction

   function automatic logic is_idx(input logic [17:0] adr,
                                   input logic [15:0] idx);
      return adr[17:2] == idx;
   endfunction

   // ****************************************
   // state
   // ****************************************
   lp_state_t state_reg, state_next;
   logic [12:0] stab_cnt_reg;
   logic [12:0] recovery_limit;
   logic wake_irq_reg;
   reg8_t rst_flags_reg, rst_events;
   reg8_t irq_low_reg, irq_mid_reg, irq_high_reg;
   logic break_exit_wait_reg;
   logic break_clear_enable_reg;
   logic short_recovery_reg;
   logic break_state_next;
   logic any_reset, any_irq, wake_evt, recovery_done;
   logic bus_req, bus_fire, bus_wr;
   reg8_t rd_byte;

   assign any_reset = |rst_events;
   assign any_irq = |irq_req_i;
   assign wake_evt = any_irq | break_req_i | any_reset;
   assign recovery_limit = short_recovery_reg ? `RECOVERY_SHORT_CYCLES
                                             : `RECOVERY_LONG_CYCLES;
   assign recovery_done = stab_cnt_reg == 13'(recovery_limit - 13'd1);
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_fire = bus_req & wb_ack_o;
   assign bus_wr = bus_fire & wb_we_i & wb_sel_i[0];

   always_comb begin
      rst_events = `REG8_ZERO;
      rst_events[`RST_POR] = por_evt_i;
      rst_events[`RST_PIN] = pin_evt_i;
      rst_events[`RST_WDOG] = wdog_evt_i;
      rst_events[`RST_ILL_OPCODE] = ill_opcode_evt_i;
      rst_events[`RST_ILL_ADDR] = ill_addr_evt_i;
      rst_events[`RST_MON_ENTRY] = mon_entry_evt_i;
      rst_events[`RST_LOW_VOLT] = low_volt_evt_i;
   end

   // ****************************************
   // wishbone slave
   // ****************************************
   always_comb begin
      rd_byte = `REG8_ZERO;
      if (is_idx(wb_adr_i, `IDX_BREAK_STATUS)) begin
         rd_byte[`BIT_BREAK_EXIT_WAIT] = break_exit_wait_reg;
      end else if (is_idx(wb_adr_i, `IDX_RESET_SOURCE_STATUS)) begin
         rd_byte = rst_flags_reg;
      end else if (is_idx(wb_adr_i, `IDX_BREAK_FLAG_CONTROL)) begin
         rd_byte[`BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_reg;
      end else if (is_idx(wb_adr_i, `IDX_IRQ_FLAGS_LOW)) begin
         rd_byte = irq_low_reg;
      end else if (is_idx(wb_adr_i, `IDX_IRQ_FLAGS_MID)) begin
         rd_byte = irq_mid_reg;
      end else if (is_idx(wb_adr_i, `IDX_IRQ_FLAGS_HIGH)) begin
         rd_byte = irq_high_reg;
      end else if (is_idx(wb_adr_i, `IDX_OPTION_WORD_ONE)) begin
         rd_byte[`BIT_SHORT_RECOVERY] = short_recovery_reg;
      end
   end

   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (clk_en) begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         break_clear_enable_reg <= 1'b0;
         short_recovery_reg <= 1'b0;
      end else if (clk_en && bus_wr) begin
         if (is_idx(wb_adr_i, `IDX_BREAK_FLAG_CONTROL)) begin
            break_clear_enable_reg <=
               wb_dat_i[`BIT_BREAK_CLEAR_ENABLE];
         end
         if (is_idx(wb_adr_i, `IDX_OPTION_WORD_ONE)) begin
            short_recovery_reg <= wb_dat_i[`BIT_SHORT_RECOVERY];
         end
      end
   end

   // ****************************************
   // reset source flags
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_flags_reg <= `RESET_SOURCE_INIT;
      end else if (clk_en) begin
         if (por_evt_i) begin
            rst_flags_reg <= `RESET_SOURCE_INIT;
         end else if (bus_fire && !wb_we_i &&
                      is_idx(wb_adr_i, `IDX_RESET_SOURCE_STATUS)) begin
            // only the bits returned are cleared; new events win
            rst_flags_reg <= (rst_flags_reg & ~wb_dat_o[7:0]) |
                             rst_events;
         end else begin
            rst_flags_reg <= rst_flags_reg | rst_events;
         end
      end
   end

   // ****************************************
   // interrupt flags and ranking
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_low_reg <= `REG8_ZERO;
         irq_mid_reg <= `REG8_ZERO;
         irq_high_reg <= `REG8_ZERO;
         irq_vector_o <= 5'h00;
      end else if (clk_en) begin
         irq_low_reg <= {irq_req_i[5:0], 2'b00};
         irq_mid_reg <= irq_req_i[13:6];
         irq_high_reg <= {6'h00, irq_req_i[15:14]};
         irq_vector_o <= rank_first(irq_req_i);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         system_reset_o <= 1'b0;
      end else if (clk_en) begin
         system_reset_o <= any_reset;
      end
   end

   // ****************************************
   // break state and flag protection
   // ****************************************
   assign break_state_next = break_req_i |
                             (break_state_o & ~break_exit_i);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         break_state_o <= 1'b0;
         force_swi_vector_o <= 1'b0;
         flag_clear_allow_o <= 1'b1;
      end else if (clk_en) begin
         break_state_o <= break_state_next;
         force_swi_vector_o <= break_req_i & ~break_state_o;
         // modules keep two-step state; only the clear is gated
         flag_clear_allow_o <= ~break_state_next |
                               break_clear_enable_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         break_exit_wait_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == ST_WAIT && break_req_i) begin
            break_exit_wait_reg <= 1'b1;
         end else if (bus_wr && is_idx(wb_adr_i, `IDX_BREAK_STATUS) &&
                      !wb_dat_i[`BIT_BREAK_EXIT_WAIT]) begin
            break_exit_wait_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // low-power sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (stop_exec_i) begin
               state_next = ST_STOP;
            end else if (wait_exec_i) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (wake_evt) begin
               state_next = ST_RUN;
            end
         end
         ST_STOP: begin
            if (wake_evt) begin
               state_next = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (recovery_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_RUN;
         cpu_clk_en_o <= 1'b1;
         periph_clk_en_o <= 1'b1;
         clear_i_mask_o <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         cpu_clk_en_o <= state_next == ST_RUN;
         periph_clk_en_o <= state_next == ST_RUN ||
                            state_next == ST_WAIT;
         clear_i_mask_o <= state_reg == ST_RUN &&
                           (wait_exec_i || stop_exec_i);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stab_cnt_reg <= 13'h0000;
      end else if (clk_en) begin
         if (state_reg == ST_RECOVER && !recovery_done) begin
            stab_cnt_reg <= stab_cnt_reg + 13'h0001;
         end else if (state_reg != ST_RECOVER) begin
            stab_cnt_reg <= 13'h0000;
         end
      end
   end

   assign stab_count_o = stab_cnt_reg;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wake_irq_reg <= 1'b0;
         stack_start_o <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == ST_STOP && wake_evt) begin
            wake_irq_reg <= any_irq & ~break_req_i & ~any_reset;
         end
         stack_start_o <= (state_reg == ST_WAIT && any_irq &&
                           !break_req_i && !any_reset) ||
                          (state_reg == ST_RECOVER && recovery_done &&
                           wake_irq_reg);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_wait_irq;
      state_reg == ST_WAIT && clk_en && any_irq && !break_req_i &&
      !any_reset;
   endsequence

   sequence s_recover_end;
      state_reg == ST_RECOVER && clk_en && recovery_done;
   endsequence

   property p_low_flags;
      clk_en |=> irq_low_reg == {$past(irq_req_i[5:0]), 2'b00};
   endproperty
   a_low_flags: assert property (p_low_flags)
      else $error("first flag register mismatch");

   property p_mid_flags;
      clk_en |=> irq_mid_reg == $past(irq_req_i[13:6]);
   endproperty
   a_mid_flags: assert property (p_mid_flags)
      else $error("second flag register mismatch");

   property p_high_flags;
      clk_en |=> irq_high_reg[7:2] == 6'h00 &&
                 irq_high_reg[1:0] == $past(irq_req_i[15:14]);
   endproperty
   a_high_flags: assert property (p_high_flags)
      else $error("third flag register mismatch");

   property p_por_clears;
      clk_en && por_evt_i |=> rst_flags_reg == `RESET_SOURCE_INIT;
   endproperty
   a_por_clears: assert property (p_por_clears)
      else $error("power-on did not isolate its flag");

   property p_read_clears;
      clk_en && bus_fire && !wb_we_i && !any_reset &&
      is_idx(wb_adr_i, `IDX_RESET_SOURCE_STATUS) |=>
         (rst_flags_reg & $past(wb_dat_o[7:0])) == `REG8_ZERO;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("reset status not cleared by read");

   property p_mask_clear;
      clk_en && state_reg == ST_RUN && wait_exec_i |=> clear_i_mask_o;
   endproperty
   a_mask_clear: assert property (p_mask_clear)
      else $error("interrupt mask not cleared on wait");

   property p_wait_clocks;
      state_reg == ST_WAIT |-> !cpu_clk_en_o && periph_clk_en_o;
   endproperty
   a_wait_clocks: assert property (p_wait_clocks)
      else $error("wait mode clocks wrong");

   property p_wait_stack;
      s_wait_irq |=> stack_start_o && state_reg == ST_RUN;
   endproperty
   a_wait_stack: assert property (p_wait_stack)
      else $error("stacking not one cycle after wait wake");

   property p_break_wait;
      clk_en && state_reg == ST_WAIT && break_req_i |=>
         break_exit_wait_reg ##0 break_state_o;
   endproperty
   a_break_wait: assert property (p_break_wait)
      else $error("break exit of wait not flagged");

   property p_stop_held;
      state_reg == ST_STOP |-> stab_cnt_reg == 13'h0000 &&
                              !cpu_clk_en_o && !periph_clk_en_o;
   endproperty
   a_stop_held: assert property (p_stop_held)
      else $error("stop mode counter or clocks wrong");

   property p_recover_stack;
      stack_start_o |-> $past(state_reg) == ST_WAIT ||
                        $past(stab_cnt_reg) ==
                        13'($past(recovery_limit) - 13'd1);
   endproperty
   a_recover_stack: assert property (p_recover_stack)
      else $error("stacking before recovery elapsed");

   property p_recover_len;
      s_recover_end |=> state_reg == ST_RUN && cpu_clk_en_o;
   endproperty
   a_recover_len: assert property (p_recover_len)
      else $error("recovery did not end at its count");

   property p_protect;
      clk_en && break_req_i && !break_clear_enable_reg |=>
         !flag_clear_allow_o;
   endproperty
   a_protect: assert property (p_protect)
      else $error("flag clearing not blocked in break");

   property p_swi;
      clk_en && break_req_i && !break_state_o |=> force_swi_vector_o;
   endproperty
   a_swi: assert property (p_swi)
      else $error("break did not force vector");

endmodule

// ---- bench/cpu_irq_model.sv ----
`timescale 1ns/1ps
// ****************************************
// cpu core and interrupt sources
// ****************************************
module cpu_irq_model (
   input wire logic clk_sys,
   output logic [15:0] irq_req,
   output logic break_req,
   output logic [9:0] strobes
);
   // strobes: 9 stop, 8 wait, 7 break exit, 6..0 reset events
   initial begin
      irq_req = 16'h0000;
      break_req = 1'b0;
      strobes = 10'h000;
   end
   // request levels held until changed
   task automatic set_lines(input logic [15:0] irq, input logic brk);
      @(posedge clk_sys);
      irq_req <= irq;
      break_req <= brk;
   endtask
   // one-cycle strobe, released at the next edge
   task automatic pulse(input logic [9:0] which);
      @(posedge clk_sys);
      strobes <= which;
      @(posedge clk_sys);
      strobes <= 10'h000;
   endtask
endmodule

// ---- bench/exception_lowpower_control_tb.sv ----
`timescale 1ns/1ps
`include "exc_lp_map.svh"
module exception_lowpower_control_tb;
   import exc_lp_pkg::*;
   logic clk_sys, resetn, wb_cyc, wb_stb, wb_we, wb_ack_o, clk_en;
   logic [3:0] wb_sel, wsel;
   logic [17:0] wb_adr;
   logic [31:0] wb_dat, wb_dat_o;
   logic [15:0] irq_req;
   logic break_req, system_reset_o, force_swi_vector_o, break_state_o;
   logic flag_clear_allow_o, clear_i_mask_o, cpu_clk_en_o;
   logic periph_clk_en_o, stack_start_o;
   logic [9:0] strobes;
   logic [4:0] irq_vector_o;
   logic [12:0] stab_count_o;
   logic [15:0] pats [4] = '{16'h0001, 16'h8000, 16'h5a3c, 16'h4000};
   reg8_t v;
   int fail_count, samples_checked, mask_cnt, swi_cnt, stack_cnt, rst_cnt;
   int n, m, s, i, k, lim;

   cpu_irq_model cpu_irq_model_inst (.clk_sys(clk_sys), .irq_req(irq_req),
      .break_req(break_req), .strobes(strobes));

   exception_lowpower_control exception_lowpower_control_inst (
      .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req_i(irq_req),
      .break_req_i(break_req), .break_exit_i(strobes[7]),
      .wait_exec_i(strobes[8]), .stop_exec_i(strobes[9]),
      .por_evt_i(strobes[6]), .pin_evt_i(strobes[5]),
      .wdog_evt_i(strobes[4]), .ill_opcode_evt_i(strobes[3]),
      .ill_addr_evt_i(strobes[2]), .mon_entry_evt_i(strobes[1]),
      .low_volt_evt_i(strobes[0]), .irq_vector_o(irq_vector_o),
      .system_reset_o(system_reset_o),
      .force_swi_vector_o(force_swi_vector_o),
      .break_state_o(break_state_o), .flag_clear_allow_o(flag_clear_allow_o),
      .clear_i_mask_o(clear_i_mask_o), .cpu_clk_en_o(cpu_clk_en_o),
      .periph_clk_en_o(periph_clk_en_o), .stack_start_o(stack_start_o),
      .stab_count_o(stab_count_o));

   // ****************************************
   // clock, pulse counters, helpers
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (clear_i_mask_o === 1'b1) mask_cnt++;
      if (force_swi_vector_o === 1'b1) swi_cnt++;
      if (stack_start_o === 1'b1) stack_cnt++;
      if (system_reset_o === 1'b1) rst_cnt++;
   end

   task automatic chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // classic cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [15:0] idx,
         input reg8_t wd, output reg8_t rd);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= wsel;
      wb_adr <= {idx, 2'b00};
      wb_dat <= {24'h000000, wd};
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [15:0] idx);
      wb(1'b0, idx, 8'h00, v);
   endtask

   task automatic wr(input logic [15:0] idx, input reg8_t d);
      reg8_t dummy;
      wb(1'b1, idx, d, dummy);
   endtask

   task automatic wait_stack(output int cnt);
      int base;
      base = stack_cnt;
      cnt = 0;
      while (stack_cnt == base && cnt < 6000) begin
         @(posedge clk_sys);
         cnt++;
      end
   endtask

   function automatic logic [4:0] exp_vec(input logic [15:0] p);
      logic [4:0] r;
      r = 5'h00;
      for (int j = 15; j >= 0; j--) if (p[j]) r = 5'(j + 1);
      return r;
   endfunction

   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      complete_run();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      wb_sel = 4'h0;
      wsel = 4'h1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 18'h00000;
      wb_dat = 32'h00000000;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(`IDX_RESET_SOURCE_STATUS);
      chk("reset status init", v, 8'h80);
      rd(`IDX_RESET_SOURCE_STATUS);
      chk("reset status reread", v, 8'h00);
      rd(`IDX_BREAK_STATUS);
      chk("break status init", v, 8'h00);
      for (i = 0; i < 7; i++) begin
         cpu_irq_model_inst.pulse(10'h001 << i);
         rd(`IDX_RESET_SOURCE_STATUS);
         chk("reset flag", v, 8'h02 << i);
      end
      chk("reset outputs", rst_cnt, 7);
      cpu_irq_model_inst.pulse(10'h020);
      cpu_irq_model_inst.pulse(10'h010);
      rd(`IDX_RESET_SOURCE_STATUS);
      chk("reset flags kept", v, 8'h60);
      cpu_irq_model_inst.pulse(10'h020);
      cpu_irq_model_inst.pulse(10'h040);
      rd(`IDX_RESET_SOURCE_STATUS);
      chk("power-on wipes", v, 8'h80);
      // frozen clock enable: a reset event must leave no trace
      clk_en <= 1'b0;
      cpu_irq_model_inst.pulse(10'h010);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      rd(`IDX_RESET_SOURCE_STATUS);
      chk("frozen flags", v, 8'h00);
      chk("frozen reset output", rst_cnt, 11);
      $display("test reset sources finished");

      for (k = 0; k < 4; k++) begin
         cpu_irq_model_inst.set_lines(pats[k], 1'b0);
         @(posedge clk_sys);
         rd(`IDX_IRQ_FLAGS_LOW);
         chk("flags low", v, {pats[k][5:0], 2'b00});
         rd(`IDX_IRQ_FLAGS_MID);
         chk("flags mid", v, pats[k][13:6]);
         rd(`IDX_IRQ_FLAGS_HIGH);
         chk("flags high", v, {6'h00, pats[k][15:14]});
         chk("vector", irq_vector_o, exp_vec(pats[k]));
      end
      wr(16'h0100, 8'hff);
      rd(16'h0100);
      chk("unmapped", v, 8'h00);
      rd(16'hfe02);
      chk("gap", v, 8'h00);
      wr(`IDX_BREAK_FLAG_CONTROL, 8'hff);
      rd(`IDX_BREAK_FLAG_CONTROL);
      chk("clear enable set", v, 8'h80);
      wr(`IDX_BREAK_FLAG_CONTROL, 8'h00);
      rd(`IDX_BREAK_FLAG_CONTROL);
      chk("clear enable cleared", v, 8'h00);
      // write with the low byte lane disabled is ignored
      wsel = 4'h0;
      wr(`IDX_BREAK_FLAG_CONTROL, 8'h80);
      wsel = 4'h1;
      rd(`IDX_BREAK_FLAG_CONTROL);
      chk("lane disabled write", v, 8'h00);
      $display("test registers finished");

      cpu_irq_model_inst.set_lines(16'h0000, 1'b0);
      m = mask_cnt;
      cpu_irq_model_inst.pulse(10'h100);
      repeat (3) @(posedge clk_sys);
      chk("wait cpu clock", cpu_clk_en_o, 1'b0);
      chk("wait periph clock", periph_clk_en_o, 1'b1);
      chk("wait mask", mask_cnt - m, 1);
      cpu_irq_model_inst.set_lines(16'h0004, 1'b0);
      wait_stack(n);
      chk("wait wake delay", n >= 2 && n <= 5, 1'b1);
      chk("wait exit clock", cpu_clk_en_o, 1'b1);
      $display("test wait wake finished");

      cpu_irq_model_inst.set_lines(16'h0000, 1'b0);
      cpu_irq_model_inst.pulse(10'h100);
      repeat (3) @(posedge clk_sys);
      s = swi_cnt;
      cpu_irq_model_inst.set_lines(16'h0000, 1'b1);
      repeat (4) @(posedge clk_sys);
      chk("break exit clock", cpu_clk_en_o, 1'b1);
      chk("break state", break_state_o, 1'b1);
      chk("vector forced", swi_cnt - s, 1);
      chk("clear blocked", flag_clear_allow_o, 1'b0);
      rd(`IDX_BREAK_STATUS);
      chk("break left wait", v, 8'h02);
      wr(`IDX_BREAK_FLAG_CONTROL, 8'h80);
      @(posedge clk_sys);
      chk("clear allowed", flag_clear_allow_o, 1'b1);
      wr(`IDX_BREAK_STATUS, 8'h00);
      cpu_irq_model_inst.set_lines(16'h0000, 1'b0);
      cpu_irq_model_inst.pulse(10'h080);
      rd(`IDX_BREAK_STATUS);
      chk("cleared stays", v, 8'h00);
      chk("break left", break_state_o, 1'b0);
      wr(`IDX_BREAK_FLAG_CONTROL, 8'h00);
      $display("test break finished");

      // short first; long recovery is left selected at the end
      for (k = 0; k < 2; k++) begin
         lim = (k == 0) ? 32 : 4096;
         wr(`IDX_OPTION_WORD_ONE, (k == 0) ? 8'h01 : 8'h00);
         m = mask_cnt;
         cpu_irq_model_inst.pulse(10'h200);
         repeat (8) @(posedge clk_sys);
         chk("stop cpu clock", cpu_clk_en_o, 1'b0);
         chk("stop periph clock", periph_clk_en_o, 1'b0);
         chk("stop counter held", stab_count_o, 13'h0000);
         chk("stop mask", mask_cnt - m, 1);
         cpu_irq_model_inst.set_lines(16'h0800, 1'b0);
         wait_stack(n);
         chk("recovery time", n >= lim && n <= lim + 4, 1'b1);
         chk("recovered clock", cpu_clk_en_o, 1'b1);
         cpu_irq_model_inst.set_lines(16'h0000, 1'b0);
      end
      $display("test stop recovery finished");
      complete_run();
   end
endmodule
